// file: hdl/fovb_cfg.svh
`ifndef FOVB_CFG_SVH
`define FOVB_CFG_SVH

// ************************************
// register offsets
// ************************************
`define FOVB_FAST_OCP_OFFSET 8'h27
`define FOVB_VS_GAIN_OFFSET 8'h28
`define FOVB_SHARE_BW_OFFSET 8'h29

// ************************************
// reset values
// ************************************
`define FOVB_FAST_OCP_RESET 8'h00
`define FOVB_VS_GAIN_RESET 8'h00
`define FOVB_SHARE_BW_RESET 8'h00
`define FOVB_UNMAPPED_READ 8'h00

// ************************************
// timing
// ************************************
`define FOVB_CLK_MHZ 20
`define FOVB_DEB1_NS 40
`define FOVB_DEB2_NS 80
`define FOVB_DEB3_NS 120
`define FOVB_BLANK_NS 150
// least times round up to whole clock cycles
`define FOVB_NS_TO_CYC(ns) (((ns) * `FOVB_CLK_MHZ + 999) / 1000)
`define FOVB_DEB1_CYC 3'(`FOVB_NS_TO_CYC(`FOVB_DEB1_NS))
`define FOVB_DEB2_CYC 3'(`FOVB_NS_TO_CYC(`FOVB_DEB2_NS))
`define FOVB_DEB3_CYC 3'(`FOVB_NS_TO_CYC(`FOVB_DEB3_NS))
`define FOVB_BLANK_CYC 3'(`FOVB_NS_TO_CYC(`FOVB_BLANK_NS))
`define FOVB_VS_SETTLE_SLOW_MS 700
`define FOVB_VS_SETTLE_FAST_MS 10
`define FOVB_CONSEC_MAX 4'h8

`endif

// file: hdl/fovb_pkg.sv
package fovb_pkg;

   typedef struct packed {
      logic [1:0] debounce;
      logic vsb_enable;
      logic ocp_bypass;
      logic const_current;
      logic vsb_blank;
      logic [1:0] timeout;
   } fovb_ocp_cfg_s;

   typedef struct packed {
      logic [5:0] reserved;
      logic [1:0] gain;
   } fovb_vs_gain_s;

   typedef struct packed {
      logic [2:0] reserved;
      logic bit_stream;
      logic share_sel_primary;
      logic [2:0] bandwidth;
   } fovb_share_cfg_s;

   typedef enum logic [0:0] {
      FOVB_RUN = 1'b0,
      FOVB_CUT = 1'b1
   } fovb_pwm_state_e;

endpackage

// file: hdl/fovb_config.sv
`timescale 1ns/10ps
`default_nettype none
`include "fovb_cfg.svh"

module fovb_config (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic cycle_start,
   input wire logic [3:0] pwm_in,
   input wire logic primary_current_sense_over,
   input wire logic flag_input_pin,
   input wire logic primary_current_sense_stream,
   input wire logic secondary_current_sense_stream,
   input wire logic digital_share_bus,
   input wire logic signed [7:0] vs_error,
   output logic [3:0] pwm_out,
   output logic signed [15:0] bridge_output_b_adjust,
   output logic signed [15:0] bridge_output_d_adjust,
   output logic fast_ocp_flag,
   output logic share_output_pin,
   output logic share_sel_primary,
   output logic [2:0] share_bandwidth,
   output logic [6:0] vs_gain_factor
);

   // ************************************
   // register file
   // ************************************
   fovb_pkg::fovb_ocp_cfg_s ocp_cfg_reg;
   fovb_pkg::fovb_vs_gain_s vs_gain_reg;
   fovb_pkg::fovb_share_cfg_s share_cfg_reg;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ocp_cfg_reg <= `FOVB_FAST_OCP_RESET;
         vs_gain_reg <= `FOVB_VS_GAIN_RESET;
         share_cfg_reg <= `FOVB_SHARE_BW_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            `FOVB_FAST_OCP_OFFSET: begin
               ocp_cfg_reg <= reg_wdata;
            end
            `FOVB_VS_GAIN_OFFSET: begin
               vs_gain_reg <= reg_wdata;
            end
            `FOVB_SHARE_BW_OFFSET: begin
               share_cfg_reg <= reg_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // read data holds between strobes, there is no valid flag
   logic [7:0] reg_rdata_next;

   always_comb begin
      case (reg_addr)
         `FOVB_FAST_OCP_OFFSET: reg_rdata_next = ocp_cfg_reg;
         `FOVB_VS_GAIN_OFFSET: reg_rdata_next = vs_gain_reg;
         `FOVB_SHARE_BW_OFFSET: reg_rdata_next = share_cfg_reg;
         default: reg_rdata_next = `FOVB_UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= `FOVB_UNMAPPED_READ;
      end else if (reg_rd) begin
         reg_rdata <= reg_rdata_next;
      end
   end

   // ************************************
   // comparator source, blanking, debounce
   // ************************************
   logic ocp_raw;
   logic [3:0] pwm_in_reg;
   logic [2:0] blank_cnt_reg;
   logic [2:0] deb_cnt_reg;
   logic [2:0] deb_need;
   logic ocp_qual;
   logic trip_now;

   assign ocp_raw = ocp_cfg_reg.ocp_bypass ? flag_input_pin : primary_current_sense_over;

   // a sense measurement starts on any pwm rising edge
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwm_in_reg <= 4'h0;
         blank_cnt_reg <= 3'h0;
      end else begin
         pwm_in_reg <= pwm_in;
         if (ocp_cfg_reg.vsb_blank && |(pwm_in & ~pwm_in_reg)) begin
            blank_cnt_reg <= `FOVB_BLANK_CYC;
         end else if (blank_cnt_reg != 3'h0) begin
            blank_cnt_reg <= blank_cnt_reg - 3'h1;
         end
      end
   end

   always_comb begin
      case (ocp_cfg_reg.debounce)
         2'b00: deb_need = 3'h0;
         2'b01: deb_need = `FOVB_DEB1_CYC;
         2'b10: deb_need = `FOVB_DEB2_CYC;
         2'b11: deb_need = `FOVB_DEB3_CYC;
         default: deb_need = 3'h0;
      endcase
   end

   // blanking also covers the edge cycle itself, before the counter loads
   assign ocp_qual = ocp_raw && (blank_cnt_reg == 3'h0)
                     && !(ocp_cfg_reg.vsb_blank && |(pwm_in & ~pwm_in_reg));
   assign trip_now = ocp_qual && (deb_cnt_reg >= deb_need);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         deb_cnt_reg <= 3'h0;
      end else if (!ocp_qual) begin
         deb_cnt_reg <= 3'h0;
      end else if (deb_cnt_reg != 3'h7) begin
         deb_cnt_reg <= deb_cnt_reg + 3'h1;
      end
   end

   // ************************************
   // cycle-by-cycle cutoff
   // ************************************
   fovb_pkg::fovb_pwm_state_e pwm_state_reg;
   fovb_pkg::fovb_pwm_state_e pwm_state_next;

   always_comb begin
      case (pwm_state_reg)
         fovb_pkg::FOVB_RUN: begin
            pwm_state_next = trip_now ? fovb_pkg::FOVB_CUT : fovb_pkg::FOVB_RUN;
         end
         fovb_pkg::FOVB_CUT: begin
            // a trip in the first cycle belongs to the new cycle
            if (cycle_start && !trip_now) begin
               pwm_state_next = fovb_pkg::FOVB_RUN;
            end else begin
               pwm_state_next = fovb_pkg::FOVB_CUT;
            end
         end
         default: pwm_state_next = fovb_pkg::FOVB_RUN;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwm_state_reg <= fovb_pkg::FOVB_RUN;
         pwm_out <= 4'h0;
      end else begin
         pwm_state_reg <= pwm_state_next;
         // outputs already low stay low, active ones are gated
         pwm_out <= (pwm_state_next == fovb_pkg::FOVB_CUT) ? 4'h0 : pwm_in;
      end
   end

   // ************************************
   // consecutive-cycle timeout and flag
   // ************************************
   logic cycle_tripped_reg;
   logic [3:0] consec_reg;
   logic [3:0] consec_next;
   logic [3:0] timeout_need;
   // the count stops at eight, the longest timeout, so it cannot wrap

   always_comb begin
      case (ocp_cfg_reg.timeout)
         2'b00: timeout_need = 4'h1;
         2'b01: timeout_need = 4'h2;
         2'b10: timeout_need = 4'h4;
         2'b11: timeout_need = 4'h8;
         default: timeout_need = 4'h1;
      endcase
   end

   always_comb begin
      consec_next = consec_reg;
      if (cycle_start) begin
         if (!cycle_tripped_reg) begin
            consec_next = 4'h0;
         end else if (consec_reg != `FOVB_CONSEC_MAX) begin
            consec_next = consec_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cycle_tripped_reg <= 1'b0;
         consec_reg <= 4'h0;
         fast_ocp_flag <= 1'b0;
      end else begin
         if (cycle_start) begin
            cycle_tripped_reg <= trip_now;
         end else if (trip_now) begin
            cycle_tripped_reg <= 1'b1;
         end
         consec_reg <= consec_next;
         // judged only at a cycle boundary, so rewriting the timeout
         // between cycles cannot move the flag by itself
         if (cycle_start && (consec_next >= timeout_need)) begin
            fast_ocp_flag <= 1'b1;
         end else if (cycle_start && !cycle_tripped_reg) begin
            fast_ocp_flag <= 1'b0;
         end
      end
   end

   // ************************************
   // volt-second balance integrator
   // ************************************
   // gain steps of 4x shift the per-cycle step; 64x ends near 700/10 faster settling
   logic [2:0] vs_shift;
   logic signed [15:0] vs_acc_reg;
   logic signed [15:0] vs_step;
   logic signed [16:0] vs_sum;

   assign vs_shift = {vs_gain_reg.gain, 1'b0};
   assign vs_step = 16'(16'(vs_error) <<< vs_shift);
   assign vs_sum = 17'(vs_acc_reg) + 17'(vs_step);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         vs_acc_reg <= 16'h0000;
      end else if (!ocp_cfg_reg.vsb_enable) begin
         vs_acc_reg <= 16'h0000;
      end else if (cycle_start) begin
         // saturate rather than wrap, a wrap would flip the correction
         if (vs_sum > 17'sh0_7FFF) begin
            vs_acc_reg <= 16'sh7FFF;
         end else if (vs_sum < -17'sh0_8000) begin
            vs_acc_reg <= -16'sh8000;
         end else begin
            vs_acc_reg <= vs_sum[15:0];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         bridge_output_b_adjust <= 16'h0000;
         bridge_output_d_adjust <= 16'h0000;
         vs_gain_factor <= 7'h01;
      end else begin
         bridge_output_b_adjust <= vs_acc_reg;
         bridge_output_d_adjust <= 16'(-vs_acc_reg);
         vs_gain_factor <= 7'(7'h01 << vs_shift);
      end
   end

   // ************************************
   // share bus selection
   // ************************************
   logic share_stream;

   assign share_stream = share_cfg_reg.share_sel_primary ? primary_current_sense_stream
                                                         : secondary_current_sense_stream;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         share_output_pin <= 1'b0;
         share_sel_primary <= 1'b0;
         share_bandwidth <= 3'h0;
      end else begin
         if (share_cfg_reg.bit_stream) begin
            share_output_pin <= share_stream;
         end else begin
            share_output_pin <= digital_share_bus;
         end
         share_sel_primary <= share_cfg_reg.share_sel_primary;
         share_bandwidth <= share_cfg_reg.bandwidth;
      end
   end

endmodule
`default_nettype wire

// file: verification/fovb_config_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ************
// port checker
// ************
module fovb_config_monitor (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic cycle_start,
   input wire logic [3:0] pwm_in,
   input wire logic primary_current_sense_over,
   input wire logic flag_input_pin,
   input wire logic primary_current_sense_stream,
   input wire logic secondary_current_sense_stream,
   input wire logic digital_share_bus,
   input wire logic [3:0] pwm_out,
   input wire logic signed [15:0] bridge_output_b_adjust,
   input wire logic signed [15:0] bridge_output_d_adjust,
   input wire logic fast_ocp_flag,
   input wire logic share_output_pin,
   input wire logic share_sel_primary,
   input wire logic [2:0] share_bandwidth,
   input wire logic [6:0] vs_gain_factor
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic [7:0] ocp_reg;
   logic bs_reg;
   // shadows of fields that have no port of their own
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ocp_reg <= 8'h00;
         bs_reg <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == 8'h27)
            ocp_reg <= reg_wdata;
         if (reg_addr == 8'h29)
            bs_reg <= reg_wdata[4];
      end
   end
   sequence bw_wr_s;
      reg_wr && reg_addr == 8'h29;
   endsequence
   // two quiet cycles, so the registered select copy has caught up
   sequence quiet_s;
      !reg_wr ##1 !reg_wr;
   endsequence
   gain_code_a: assert property (vs_gain_factor inside {7'h01, 7'h04, 7'h10, 7'h40})
      else $error("gain factor off code");
   share_mux_a: assert property (quiet_s |=> share_output_pin == $past(bs_reg ? (share_sel_primary ?
      primary_current_sense_stream : secondary_current_sense_stream) : digital_share_bus))
      else $error("share pin source wrong");
   bw_copy_a: assert property (bw_wr_s |=> ##1 {share_sel_primary, share_bandwidth} == $past(reg_wdata[3:0], 2))
      else $error("share copy wrong");
   pwm_gate_a: assert property (pwm_out == 4'h0 || pwm_out == $past(pwm_in))
      else $error("pwm neither cut nor passed");
   trip_cut_a: assert property ((ocp_reg & 8'hD4) == 8'h00 && primary_current_sense_over |=> pwm_out == 4'h0)
      else $error("trip did not cut pwm");
   bypass_cut_a: assert property ((ocp_reg & 8'hD4) == 8'h10 && flag_input_pin |=> pwm_out == 4'h0)
      else $error("bypass trip did not cut");
   flag_edge_a: assert property ($changed(fast_ocp_flag) |-> $past(cycle_start))
      else $error("flag moved off cycle start");
   adj_pair_a: assert property (bridge_output_d_adjust + bridge_output_b_adjust == 16'sh0000)
      else $error("d adjust not minus b");
endmodule
bind fovb_config fovb_config_monitor u_mon (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .cycle_start,
   .pwm_in, .primary_current_sense_over, .flag_input_pin, .primary_current_sense_stream,
   .secondary_current_sense_stream, .digital_share_bus, .pwm_out, .bridge_output_b_adjust,
   .bridge_output_d_adjust, .fast_ocp_flag, .share_output_pin, .share_sel_primary, .share_bandwidth,
   .vs_gain_factor);
`default_nettype wire

// file: verification/fovb_share_model.sv
`timescale 1ns/10ps
`default_nettype none
// ************
// share bus neighbour
// ************
module fovb_share_model (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic share_output_pin,
   output logic digital_share_bus
);
   logic [7:0] lfsr_reg;
   // shifts in a fresh bit every cycle, so a stale sample is caught only when that bit differs
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         lfsr_reg <= 8'h01;
      else
         lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ share_output_pin};
   end
   assign digital_share_bus = lfsr_reg[0];
endmodule
`default_nettype wire

// file: verification/tb_fast_ocp_vs_balance_share_config.sv
`timescale 1ns/10ps
`default_nettype none
// ************
// bench
// ************
module tb_fast_ocp_vs_balance_share_config;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, cycle_start = 1'b0, flag_input_pin = 1'b0;
   logic primary_current_sense_over = 1'b0, primary_current_sense_stream = 1'b0;
   logic secondary_current_sense_stream = 1'b0, digital_share_bus, e;
   logic [3:0] pwm_in = 4'hF, pwm_out;
   logic signed [7:0] vs_error = 8'sh00;
   logic signed [15:0] bridge_output_b_adjust, bridge_output_d_adjust;
   logic fast_ocp_flag, share_output_pin, share_sel_primary;
   logic [2:0] share_bandwidth;
   logic [6:0] vs_gain_factor;
   logic [31:0] seed = 32'h0000_9336;
   logic [7:0] mem [3] = '{8'h00, 8'h00, 8'h00};
   int err_count = 0, n_checks = 0, nn = 0, kk = 1, cnt = 0, byp = 0, blk = 0, src = 0, tr = 0, v;
   always #25 core_clk = ~core_clk;
   fovb_config DUT (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cycle_start, .pwm_in,
      .primary_current_sense_over, .flag_input_pin, .primary_current_sense_stream, .secondary_current_sense_stream,
      .digital_share_bus, .vs_error, .pwm_out, .bridge_output_b_adjust, .bridge_output_d_adjust, .fast_ocp_flag,
      .share_output_pin, .share_sel_primary, .share_bandwidth, .vs_gain_factor);
   fovb_share_model u_bus (.core_clk, .rst_b, .share_output_pin, .digital_share_bus);
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic tick();
      @(negedge core_clk);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one idle cycle after each strobe, so no strobe is set twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick();
      reg_wr = 1'b0;
      tick();
      if (a >= 8'h27 && a <= 8'h29)
         mem[a - 8'h27] = d;
   endtask
   task automatic rd(input logic [7:0] a);
      reg_addr = a;
      reg_rd = 1'b1;
      tick();
      reg_rd = 1'b0;
      chk(reg_rdata, (a >= 8'h27 && a <= 8'h29) ? mem[a - 8'h27] : 8'h00);
      tick();
   endtask
   task automatic ocp(input int d, input int b, input int bl, input int t);
      wr(8'h27, 8'((d << 6) | (b << 4) | (bl << 2) | t));
      nn = d;
      byp = b;
      blk = bl;
      kk = 1 << t;
   endtask
   // one switching cycle of 8 clocks, comparator held w clocks after its start
   task automatic cyc(input int w);
      cnt = tr ? cnt + 1 : 0;
      // blanking masks the rising-edge clock and the three after it
      tr = (w > nn + 4 * blk && src == byp);
      cycle_start = 1'b1;
      if (blk)
         pwm_in = 4'h0;
      tick();
      cycle_start = 1'b0;
      chk(fast_ocp_flag, cnt >= kk);
      chk(pwm_out, pwm_in);
      for (int i = 0; i < 7; i++) begin
         pwm_in = 4'hF;
         primary_current_sense_over = (i < w && src == 0);
         flag_input_pin = (i < w && src == 1);
         tick();
         chk(pwm_out, (tr && i >= nn + 4 * blk) ? 4'h0 : 4'hF);
      end
   endtask
   initial begin
      repeat (4) tick();
      rst_b = 1'b1;
      chk(vs_gain_factor, 16'h0001);
      for (int a = 39; a < 43; a++)
         rd(8'(a));
      for (int g = 0; g < 4; g++) begin
         wr(8'h28, 8'(xs() << 2) | 8'(g));
         wr(8'h27, 8'h00);
         wr(8'h27, 8'h20);
         chk(vs_gain_factor, 16'(1 << (2 * g)));
         vs_error = 8'(xs());
         cycle_start = 1'b1;
         tick();
         cycle_start = 1'b0;
         tick();
         v = vs_error * (1 << (2 * g));
         v = (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
         chk(bridge_output_b_adjust, 16'(v));
         chk(bridge_output_d_adjust, 16'(-v));
      end
      wr(8'h27, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(8'h29, 8'(xs() & 32'h0000_00E7) | 8'(m << 3));
         for (int i = 0; i < 6; i++) begin
            {primary_current_sense_stream, secondary_current_sense_stream} = 2'(xs());
            pwm_in = 4'(xs());
            e = mem[2][4] ? (mem[2][3] ? primary_current_sense_stream : secondary_current_sense_stream)
               : digital_share_bus;
            tick();
            chk(share_output_pin, e);
         end
         chk({share_sel_primary, share_bandwidth}, mem[2][3:0]);
      end
      for (int t = 0; t < 4; t++) begin
         ocp(0, 0, 0, t);
         cyc(0);
         repeat ((1 << t) + 1) cyc(1);
         cyc(0);
      end
      for (int d = 1; d < 4; d++) begin
         ocp(d, 0, 0, 0);
         cyc(d);
         cyc(d + 1);
         cyc(0);
      end
      ocp(0, 1, 0, 0);
      src = 1;
      cyc(1);
      src = 0;
      cyc(1);
      cyc(0);
      ocp(0, 0, 1, 0);
      cyc(4);
      cyc(6);
      cyc(0);
      wr(8'h2A, 8'(xs()));
      for (int a = 39; a < 43; a++)
         rd(8'(a));
      end_sim();
   end
   initial begin
      #2000000;
      err_count++;
      end_sim();
   end
endmodule
`default_nettype wire
